// file: src/csc_pkg.sv
// constants and carrier types for the compare/call/indexed-move executor
// assumes a core that issues one decoded instruction word per cycle
//
// What this block does
// [RULE1] unsigned file-less-than-working compare, skip, no flags
// [RULE2] compare decodes 0110 000a with 8-bit address
// [RULE3] skip inserts one nop, two for double word
// [RULE4] indirect call pushes pc plus two
// [RULE5] working register loads program counter low byte
// [RULE6] latches load program counter high and upper
// [RULE7] indirect call takes two cycles, second nop
// [RULE8] indirect call never writes shadow registers
// [RULE9] source is pointer two plus 7-bit offset
// [RULE10] destination is 12-bit literal of second word
// [RULE11] both addresses span whole 4096-byte space
// [RULE12] software avoids pc low and stack-top destinations
// [RULE13] move: read source, then write destination
// [RULE14] move occupies two words, offset then destination
// [RULE15] indirect register source reads as zero
// [RULE16] selector zero access bank, one uses bank select
package csc_pkg;
    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [6:0] CSC_OP_CMPLT = 7'h30; // 0110 000
    localparam logic [15:0] CSC_OP_REGISTER_INDIRECT_SUBROUTINE_JUMP = 16'h0014;
    localparam logic [4:0] CSC_OP_MOVIDX = 5'h16; // 1011 0
    localparam logic [20:0] CSC_PC_STEP = 21'h000002;
    localparam logic [7:0] CSC_ZERO_BYTE = 8'h00;
    // access bank split: low addresses map to bank 0, rest to bank 15
    localparam logic [7:0] CSC_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] CSC_ACCESS_HIGH_BANK = 4'hF;
    // indirect data register window (addresses that read as zero)
    localparam logic [11:0] CSC_INDIRECT_LO = 12'hFDB;
    localparam logic [11:0] CSC_INDIRECT_HI = 12'hFEF;
    localparam logic [20:0] CSC_PC_RESET = 21'h000000;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic re;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } csc_mem_req_t;

    typedef struct packed {
        logic push;
        logic [20:0] ret_addr;
    } csc_stack_req_t;
endpackage

// file: src/csc_addr_gen.sv
// address generation for the executor
// assumes pointer and bank values are stable during the cycle
`timescale 1ns/1ps
module csc_addr_gen
    import csc_pkg::*;
(
    input wire logic [7:0] file_addr_in,
    input wire logic access_sel_in,
    input wire logic [3:0] bank_select_in,
    input wire logic [11:0] pointer_two_in,
    input wire logic [6:0] offset_in,
    output logic [11:0] file_full_out,
    output logic [11:0] src_addr_out,
    output logic src_indirect_out
);
    // ------------------------------------------------------------
    // banked and indexed addresses
    // ------------------------------------------------------------
    wire logic low_half = file_addr_in < CSC_ACCESS_SPLIT;
    wire logic [3:0] access_bank = low_half ? 4'h0 : CSC_ACCESS_HIGH_BANK;
    assign file_full_out = {access_sel_in ? bank_select_in : access_bank,
                            file_addr_in}; // RULE16
    assign src_addr_out = pointer_two_in + {5'h00, offset_in}; // RULE9 RULE11
    assign src_indirect_out = (src_addr_out >= CSC_INDIRECT_LO)
                            && (src_addr_out <= CSC_INDIRECT_HI); // RULE15
endmodule // csc_addr_gen

// file: src/csc_exec.sv
// execution of compare-skip, indirect call and indexed move
// assumes the core presents one word per cycle with a valid strobe
`timescale 1ns/1ps
module csc_exec
    import csc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic next_is_double_in,
    input wire logic [20:0] pc_in,
    input wire logic [7:0] working_register_in,
    input wire logic [7:0] counter_high_latch_in,
    input wire logic [4:0] counter_upper_latch_in,
    input wire logic [3:0] bank_select_register_in,
    input wire logic [11:0] indirect_pointer_two_in,
    input wire logic [7:0] mem_rdata_in,
    output csc_mem_req_t mem_req_out,
    output csc_stack_req_t stack_req_out,
    output logic pc_load_out,
    output logic [20:0] pc_value_out,
    output logic nop_slot_out,
    output logic shadow_write_out,
    output logic flags_write_out,
    output logic busy_out
);
    typedef enum logic [2:0] {
        S_IDLE, S_SKIP1, S_SKIP2, S_CALL2, S_MOVE2
    } csc_state_t;

    csc_state_t state_reg, state_next;
    logic [7:0] data_reg, data_next;
    csc_mem_req_t mem_reg, mem_next;
    csc_stack_req_t stk_reg, stk_next;
    logic pc_load_reg, pc_load_next;
    logic [20:0] pc_val_reg, pc_val_next;
    logic nop_reg, nop_next;
    logic busy_reg, busy_next;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic idle = state_reg == S_IDLE;
    wire logic go = idle && instr_valid_in;
    wire logic is_cmp = go && instr_word_in[15:9] == CSC_OP_CMPLT; // RULE2
    wire logic is_call = go && instr_word_in == CSC_OP_REGISTER_INDIRECT_SUBROUTINE_JUMP;
    wire logic is_move = go && instr_word_in[15:11] == CSC_OP_MOVIDX; // RULE14
    wire logic [11:0] file_full;
    wire logic [11:0] src_addr;
    wire logic src_ind;
    // unsigned less-than decides the skip
    wire logic less = mem_rdata_in < working_register_in; // RULE1

    csc_addr_gen u_addr (
        .file_addr_in(instr_word_in[7:0]),
        .access_sel_in(instr_word_in[8]),
        .bank_select_in(bank_select_register_in),
        .pointer_two_in(indirect_pointer_two_in),
        .offset_in(instr_word_in[6:0]),
        .file_full_out(file_full),
        .src_addr_out(src_addr),
        .src_indirect_out(src_ind)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        data_next = data_reg;
        mem_next = '0;
        stk_next = '0;
        pc_load_next = 1'b0;
        pc_val_next = pc_val_reg;
        nop_next = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (is_cmp) begin
                    mem_next.re = 1'b1;
                    mem_next.addr = file_full;
                    if (less) begin
                        state_next = S_SKIP1; // RULE3
                    end
                end else if (is_call) begin
                    stk_next.push = 1'b1;
                    stk_next.ret_addr = pc_in + CSC_PC_STEP; // RULE4
                    pc_load_next = 1'b1;
                    pc_val_next = {counter_upper_latch_in, counter_high_latch_in,
                                   working_register_in}; // RULE5 RULE6
                    state_next = S_CALL2; // RULE7
                end else if (is_move) begin
                    mem_next.re = 1'b1;
                    mem_next.addr = src_addr;
                    data_next = src_ind ? CSC_ZERO_BYTE : mem_rdata_in; // RULE13 RULE15
                    state_next = S_MOVE2;
                end
            end
            S_SKIP1: begin
                nop_next = 1'b1;
                state_next = next_is_double_in ? S_SKIP2 : S_IDLE; // RULE3
            end
            S_SKIP2: begin
                nop_next = 1'b1;
                state_next = S_IDLE;
            end
            S_CALL2: begin
                nop_next = 1'b1; // RULE7
                state_next = S_IDLE;
            end
            S_MOVE2: begin
                if (instr_valid_in) begin
                    mem_next.we = 1'b1;
                    mem_next.addr = instr_word_in[11:0]; // RULE10
                    mem_next.wdata = data_reg;
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
        // busy follows the state about to be entered, so it leaves a flop
        busy_next = state_next != S_IDLE;
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= S_IDLE;
            data_reg <= 8'h00;
            mem_reg <= '0;
            stk_reg <= '0;
            pc_load_reg <= 1'b0;
            pc_val_reg <= CSC_PC_RESET;
            nop_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            data_reg <= data_next;
            mem_reg <= mem_next;
            stk_reg <= stk_next;
            pc_load_reg <= pc_load_next;
            pc_val_reg <= pc_val_next;
            nop_reg <= nop_next;
            busy_reg <= busy_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mem_req_out = mem_reg;
    assign stack_req_out = stk_reg;
    assign pc_load_out = pc_load_reg;
    assign pc_value_out = pc_val_reg;
    assign nop_slot_out = nop_reg;
    assign busy_out = busy_reg;
    // no shadow or status writes from these instructions
    assign shadow_write_out = 1'b0; // RULE8
    assign flags_write_out = 1'b0; // RULE1

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_call_push;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        is_call |=> stack_req_out.push && stack_req_out.ret_addr == $past(pc_in) + CSC_PC_STEP;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong"); // RULE4
    property p_call_pc;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        is_call |=> pc_load_out && pc_value_out[7:0] == $past(working_register_in)
            && pc_value_out[15:8] == $past(counter_high_latch_in)
            && pc_value_out[20:16] == $past(counter_upper_latch_in);
    endproperty
    a_call_pc: assert property (p_call_pc) else $error("call target wrong"); // RULE5 RULE6
    property p_call_nop;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        is_call |=> ##1 nop_slot_out ##1 !busy_out;
    endproperty
    a_call_nop: assert property (p_call_nop) else $error("call timing"); // RULE7
    property p_skip;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (is_cmp && less) |=> ##1 nop_slot_out;
    endproperty
    a_skip: assert property (p_skip) else $error("skip missing"); // RULE3
    property p_noskip;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (is_cmp && !less) |=> !busy_out;
    endproperty
    a_noskip: assert property (p_noskip) else $error("spurious skip"); // RULE1
    property p_cmp_addr;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (is_cmp && instr_word_in[8]) |=>
            mem_req_out.addr[11:8] == $past(bank_select_register_in);
    endproperty
    a_cmp_addr: assert property (p_cmp_addr) else $error("bank wrong"); // RULE16
    property p_move_src;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        is_move |=> mem_req_out.re
            && mem_req_out.addr == $past(indirect_pointer_two_in) + {5'h00, $past(instr_word_in[6:0])};
    endproperty
    a_move_src: assert property (p_move_src) else $error("source wrong"); // RULE9
    property p_move_dst;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_reg == S_MOVE2 && instr_valid_in) |=>
            mem_req_out.we && mem_req_out.addr == $past(instr_word_in[11:0]);
    endproperty
    a_move_dst: assert property (p_move_dst) else $error("dest wrong"); // RULE10 RULE13
    property p_shadow;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        !shadow_write_out && !flags_write_out;
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow write"); // RULE8
    property p_skip2;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_reg == S_SKIP1 && next_is_double_in) |=> ##1 nop_slot_out;
    endproperty
    a_skip2: assert property (p_skip2) else $error("second skip nop missing"); // RULE3
    property p_move_zero;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (is_move && src_ind) |=> data_reg == CSC_ZERO_BYTE;
    endproperty
    a_move_zero: assert property (p_move_zero) else $error("indirect source not zero"); // RULE15
    c_call: cover property (@(posedge ref_clk_in) is_call);
    c_skip2: cover property (@(posedge ref_clk_in) state_reg == S_SKIP2);
    c_move: cover property (@(posedge ref_clk_in) state_reg == S_MOVE2 ##1 mem_req_out.we);
endmodule // csc_exec

// file: bench/tb_compare_skip_call_indexed_move.sv
// self-checking bench for the compare/call/indexed-move executor
// assumes csc_pkg and csc_exec compiled first; bench drives every port
`timescale 1ns/1ps
module tb_compare_skip_call_indexed_move;
    import csc_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic instr_valid_in = 1'b0;
    logic next_is_double_in = 1'b0;
    logic [15:0] instr_word_in = 16'h0000;
    logic [20:0] pc_in = 21'h000000;
    logic [7:0] working_register_in = 8'h00;
    logic [7:0] counter_high_latch_in = 8'h00;
    logic [4:0] counter_upper_latch_in = 5'h00;
    logic [3:0] bank_select_register_in = 4'h0;
    logic [11:0] indirect_pointer_two_in = 12'h000;
    logic [7:0] mem_rdata_in = 8'h00;
    csc_mem_req_t mem_req_out;
    csc_stack_req_t stack_req_out;
    logic pc_load_out, nop_slot_out, shadow_write_out, flags_write_out, busy_out;
    logic [20:0] pc_value_out, ret_seen, pcv_seen;
    logic [11:0] addr_seen, waddr_seen;
    logic [7:0] wdata_seen, f, w;
    int error_cnt = 0, n_checks = 0, seed = 32'h5b6d652b;
    int re_n, we_n, push_n, load_n, nop_n, stray_n;
    logic cnt_clr = 1'b0;

    csc_exec dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
        .next_is_double_in(next_is_double_in), .pc_in(pc_in),
        .working_register_in(working_register_in),
        .counter_high_latch_in(counter_high_latch_in),
        .counter_upper_latch_in(counter_upper_latch_in),
        .bank_select_register_in(bank_select_register_in),
        .indirect_pointer_two_in(indirect_pointer_two_in), .mem_rdata_in(mem_rdata_in),
        .mem_req_out(mem_req_out), .stack_req_out(stack_req_out),
        .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
        .nop_slot_out(nop_slot_out), .shadow_write_out(shadow_write_out),
        .flags_write_out(flags_write_out), .busy_out(busy_out));

    // 100 ns clock
    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    // pulse counters sampled at the rising edge, values captured on pulse
    always @(posedge ref_clk_in) begin
        // counters other than stray_n restart at the edge that takes a new instruction
        if (cnt_clr) {re_n, we_n, push_n, load_n, nop_n} = 160'h0;
        if (mem_req_out.re === 1'b1) begin re_n++; addr_seen = mem_req_out.addr; end
        if (mem_req_out.we === 1'b1) begin
            we_n++;
            waddr_seen = mem_req_out.addr;
            wdata_seen = mem_req_out.wdata;
        end
        if (stack_req_out.push === 1'b1) begin push_n++; ret_seen = stack_req_out.ret_addr; end
        if (pc_load_out === 1'b1) begin load_n++; pcv_seen = pc_value_out; end
        if (nop_slot_out === 1'b1) nop_n++;
        if (shadow_write_out !== 1'b0 || flags_write_out !== 1'b0) stray_n++;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("TB: checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // issue one or two words after the block is idle, then let results land
    task automatic go(input logic [15:0] w1, input bit two, input logic [15:0] w2);
        int k;
        k = 0;
        @(negedge ref_clk_in);
        while (busy_out !== 1'b0) begin
            k++;
            if (k > 20) begin error_cnt++; $display("ERROR busy expected 0 seen 1"); test_done(); end
            @(negedge ref_clk_in);
        end
        cnt_clr = 1'b1;
        instr_word_in = w1;
        instr_valid_in = 1'b1;
        @(negedge ref_clk_in);
        cnt_clr = 1'b0;
        if (two) begin instr_word_in = w2; @(negedge ref_clk_in); end
        instr_valid_in = 1'b0;
        repeat (5) @(negedge ref_clk_in);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin : main
        logic a;
        logic [11:0] exp_addr, src, dst, ptr;
        logic [6:0] off;
        repeat (2) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        // compare-skip: equal, access split edge at 0x60, both selectors, one/two word skips
        for (int i = 0; i < 16; i++) begin
            f = 8'($random(seed));
            w = 8'($random(seed));
            if (i == 0) w = f;
            if (i == 3) f = 8'h5F;
            if (i == 5) f = 8'h60;
            a = i[1];
            bank_select_register_in = 4'($random(seed));
            next_is_double_in = i[2];
            working_register_in = w;
            mem_rdata_in = f;
            exp_addr = a ? {bank_select_register_in, f} : (f < 8'h60 ? {4'h0, f} : {4'hF, f});
            go({4'h6, 3'h0, a, f}, 1'b0, 16'h0000);
            chk("cmp_reads", 1, re_n);
            chk("cmp_addr", exp_addr, addr_seen);
            chk("cmp_nops", (f < w) ? (i[2] ? 2 : 1) : 0, nop_n);
            chk("cmp_side", 0, we_n + push_n + load_n);
        end
        $display("TB: compare test done");
        // register-indirect call
        for (int i = 0; i < 4; i++) begin
            pc_in = 21'($random(seed)) & 21'h1FFFFE;
            working_register_in = 8'($random(seed));
            counter_high_latch_in = 8'($random(seed));
            counter_upper_latch_in = 5'($random(seed));
            go(16'h0014, 1'b0, 16'h0000);
            chk("call_push", 1, push_n);
            chk("call_ret", 21'(pc_in + 21'h000002), ret_seen);
            chk("call_load", 1, load_n);
            chk("call_pc", {counter_upper_latch_in, counter_high_latch_in,
                working_register_in}, pcv_seen);
            chk("call_nop", 1, nop_n);
        end
        $display("TB: call test done");
        // indexed move: indirect source, wraparound, address extremes
        for (int i = 0; i < 8; i++) begin
            ptr = 12'($random(seed));
            off = 7'($random(seed));
            dst = 12'($random(seed));
            if (i == 0) begin ptr = 12'hFD0; off = 7'h0B; end
            if (i == 1) begin ptr = 12'hFFF; off = 7'h7F; dst = 12'hFFC; end
            if (i == 2) begin ptr = 12'h000; off = 7'h00; dst = 12'h000; end
            if (i == 3) begin ptr = 12'hF70; off = 7'h7F; end
            // stay off counter low and stack-top destinations
            if (dst == 12'hFF9 || dst >= 12'hFFD) dst = 12'hFFC;
            src = ptr + {5'h00, off};
            indirect_pointer_two_in = ptr;
            mem_rdata_in = 8'($random(seed));
            go({4'hB, 5'h00, off}, 1'b1, {4'hF, dst});
            chk("mov_we", 1, we_n);
            chk("mov_dst", dst, waddr_seen);
            chk("mov_data", (src >= 12'hFDB && src <= 12'hFEF) ? 8'h00 : mem_rdata_in,
                wdata_seen);
            chk("mov_src", src, addr_seen);
            chk("mov_side", 0, push_n + load_n);
        end
        $display("TB: move test done");
        // reset while a move waits for its second word abandons it
        instr_word_in = {4'hB, 5'h00, 7'h01};
        instr_valid_in = 1'b1;
        @(negedge ref_clk_in);
        instr_valid_in = 1'b0;
        @(negedge ref_clk_in);
        chk("mid_busy", 1, busy_out);
        sys_rst_in = 1'b1;
        @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        chk("rst_busy", 0, busy_out);
        chk("rst_we", 0, mem_req_out.we);
        $display("TB: reset test done");
        // unknown opcode leaves everything quiet
        go(16'h0000, 1'b0, 16'h0000);
        chk("nop_quiet", 0, re_n + we_n + push_n + load_n + nop_n);
        chk("no_shadow_flags", 0, stray_n);
        $display("TB: quiet test done");
        test_done();
    end
endmodule // tb_compare_skip_call_indexed_move
